// *** rtl/bss_top.sv ***
// boot source select with reset stretcher
`timescale 1ns/1ps
`include "bss_params.svh"

module bss_top
  import bss_pkg::*;
#(
  parameter int unsigned TRIG_CYCLES = `BSS_TRIG_CYCLES,
  parameter int unsigned HOLD_CYCLES = `BSS_HOLD_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reset_req_n,
  input wire logic boot_select_strap,
  input wire logic fuse_boot_override,
  input wire logic fuses_programmed,
  output logic int_reset_n,
  output logic boot_start,
  output logic [1:0] boot_source
);
  // counter widths follow the parameters, so tests may shrink them
  localparam int TW = $clog2(TRIG_CYCLES + 1);
  localparam int HW = $clog2(HOLD_CYCLES + 1);

  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  // assert is async, release is clocked so no flop leaves reset early
  logic rs1_q;
  logic rs2_q;
  logic rst_sync_n;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  assign rst_sync_n = rs2_q;

  logic req_n_s;
  logic strap_s;
  logic fovr_s;
  logic fprog_s;
  // strap resets high: floating pin pulls to eMMC
  bss_sync #(.RESET_VAL(1'b1)) u_req (.core_clk(core_clk), .rst_n(rst_sync_n),
    .pin_in(reset_req_n), .pin_out(req_n_s));
  bss_sync #(.RESET_VAL(1'b1)) u_strap (.core_clk(core_clk), .rst_n(rst_sync_n),
    .pin_in(boot_select_strap), .pin_out(strap_s));
  bss_sync #(.RESET_VAL(1'b0)) u_fovr (.core_clk(core_clk), .rst_n(rst_sync_n),
    .pin_in(fuse_boot_override), .pin_out(fovr_s));
  bss_sync #(.RESET_VAL(1'b0)) u_fprog (.core_clk(core_clk), .rst_n(rst_sync_n),
    .pin_in(fuses_programmed), .pin_out(fprog_s));

  // ----------------------------------------
  // source decode
  // ----------------------------------------
  // fuse choice is refused until the fuses are programmed
  function automatic logic [1:0] pick_src(input logic strap, input logic ovr, input logic prog);
    if (ovr && prog) begin
      pick_src = BSS_SRC_FUSE;
    end else if (!strap) begin
      pick_src = BSS_SRC_USB_DL;
    end else begin
      pick_src = BSS_SRC_EMMC;
    end
  endfunction

  // ----------------------------------------
  // trigger filter and hold timer
  // ----------------------------------------
  typedef enum logic [1:0] {ST_HOLD, ST_RUN} bss_st_e;
  bss_st_e st_q;
  bss_st_e st_d;
  // low_q saturates at the trigger length
  logic [TW-1:0] low_q;
  logic [TW-1:0] low_d;
  logic [HW-1:0] hold_q;
  logic [HW-1:0] hold_d;
  logic irst_n_q;
  logic irst_n_d;
  logic start_q;
  logic start_d;
  logic [1:0] src_q;
  logic [1:0] src_d;

  always_comb begin
    st_d = st_q;
    hold_d = hold_q;
    irst_n_d = irst_n_q;
    start_d = 1'b0;
    src_d = src_q;
    // shorter glitches are ignored so noise cannot restart boot
    if (req_n_s) begin
      low_d = '0;
    end else if (low_q != TW'(TRIG_CYCLES)) begin
      low_d = low_q + TW'(1);
    end else begin
      low_d = low_q;
    end
    case (st_q)
      ST_HOLD: begin
        irst_n_d = 1'b0;
        // short end of the range; a slower clock only lengthens it
        if (hold_q == HW'(HOLD_CYCLES - 1)) begin
          st_d = ST_RUN;
          irst_n_d = 1'b1;
          start_d = 1'b1;
          src_d = pick_src(strap_s, fovr_s, fprog_s);
        end else begin
          hold_d = hold_q + HW'(1);
        end
      end
      // a retrigger is taken at any time once running
      ST_RUN: begin
        if (low_d == TW'(TRIG_CYCLES)) begin
          st_d = ST_HOLD;
          hold_d = '0;
          irst_n_d = 1'b0;
        end
      end
      default: begin
        st_d = ST_HOLD;
        hold_d = '0;
      end
    endcase
    // held request keeps the stretch going until released
    if (st_q == ST_HOLD && low_q == TW'(TRIG_CYCLES) && !req_n_s) begin
      st_d = ST_HOLD;
      hold_d = '0;
      irst_n_d = 1'b0;
      start_d = 1'b0;
      src_d = src_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_q <= ST_HOLD;
      low_q <= '0;
      hold_q <= '0;
      irst_n_q <= 1'b0;
      start_q <= 1'b0;
      src_q <= `BSS_SRC_RESET;
    end else begin
      st_q <= st_d;
      low_q <= low_d;
      hold_q <= hold_d;
      irst_n_q <= irst_n_d;
      start_q <= start_d;
      src_q <= src_d;
    end
  end

  // outputs come straight from flops, so the pins never glitch
  assign int_reset_n = irst_n_q;
  assign boot_start = start_q;
  assign boot_source = src_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // release and fall each take two samples, so they are named steps
  sequence s_rise;
    !int_reset_n ##1 int_reset_n;
  endsequence

  sequence s_fall;
    int_reset_n ##1 !int_reset_n;
  endsequence

  a_start_on_rise: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    s_rise |-> boot_start) else $error("boot start not with reset release");
  a_start_only_rise: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    boot_start |-> int_reset_n && !$past(int_reset_n)) else $error("boot start without reset release");
  a_src_stable: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (int_reset_n && $past(int_reset_n)) |-> $stable(boot_source)) else $error("source changed");
  a_src_frozen: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    !int_reset_n |-> $stable(boot_source)) else $error("source changed during reset");
  a_no_fuse_unprog: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    boot_start && !$past(fprog_s) |-> boot_source != BSS_SRC_FUSE) else $error("fuse unprogrammed");
  a_fuse_sel: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    boot_start && $past(fprog_s) && $past(fovr_s) |-> boot_source == BSS_SRC_FUSE)
    else $error("fuse override ignored");
  a_usb_sel: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    boot_start && !$past(strap_s) && !($past(fovr_s) && $past(fprog_s)) |-> boot_source == BSS_SRC_USB_DL)
    else $error("usb download not chosen");
  a_emmc_sel: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    boot_start && $past(strap_s) && !($past(fovr_s) && $past(fprog_s)) |-> boot_source == BSS_SRC_EMMC)
    else $error("emmc not chosen");

  // the filter must neither overrun nor fire on a short pulse
  a_low_sat: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    low_q <= TW'(TRIG_CYCLES)) else $error("trigger count overran");
  a_trig_acts: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (st_q == ST_RUN && low_d == TW'(TRIG_CYCLES)) |=> !int_reset_n) else $error("trigger missed");
  a_glitch_ignored: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (st_q == ST_RUN && low_d != TW'(TRIG_CYCLES)) |=> int_reset_n) else $error("short pulse caused reset");
  a_fall_on_trig: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    s_fall |-> low_q == TW'(TRIG_CYCLES)) else $error("reset without full trigger");

  // internal reset stays low for the whole hold count
  a_hold_low: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    (st_q == ST_HOLD && hold_q != HW'(HOLD_CYCLES - 1)) |=> !int_reset_n) else $error("reset released early");
  a_hold_len: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    s_rise |-> $past(hold_q) == HW'(HOLD_CYCLES - 1)) else $error("hold length wrong");
  a_run_high: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    st_q == ST_RUN |-> int_reset_n) else $error("reset low while running");
  a_pulse_one: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
    boot_start |=> !boot_start) else $error("start pulse too long");
endmodule // bss_top

// *** rtl/bss_params.svh ***
// constants for the boot source select block
`ifndef BSS_PARAMS_SVH
`define BSS_PARAMS_SVH
`define BSS_CLK_HZ 10000000
`define BSS_TRIG_MIN_NS 20000
`define BSS_HOLD_MIN_MS 140
`define BSS_HOLD_MAX_MS 280
`define BSS_TRIG_CYCLES ((`BSS_TRIG_MIN_NS * (`BSS_CLK_HZ / 1000000) + 999) / 1000)
`define BSS_HOLD_CYCLES (`BSS_HOLD_MIN_MS * (`BSS_CLK_HZ / 1000))
`define BSS_SRC_RESET 2'h0
`endif

// *** rtl/bss_pkg.sv ***
// types for the boot source select block
package bss_pkg;
  typedef enum logic [1:0] {
    BSS_SRC_EMMC,
    BSS_SRC_USB_DL,
    BSS_SRC_FUSE
  } bss_src_e;
endpackage

// *** rtl/bss_sync.sv ***
// two-flop synchroniser for a pin level
`timescale 1ns/1ps
module bss_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic pin_out
);
  logic meta_q;
  logic meta_d;
  logic out_q;
  logic out_d;

  always_comb begin
    meta_d = pin_in;
    out_d = meta_q;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RESET_VAL;
      out_q <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      out_q <= out_d;
    end
  end

  assign pin_out = out_q;
endmodule // bss_sync

// *** tb/bss_board.sv ***
// carrier board model: reset button and boot strap
`timescale 1ns/1ps
module bss_board (
  input wire logic core_clk,
  output logic reset_req_n,
  output logic boot_select_strap
);
  logic strap_low = 1'b0;
  logic reset_req_q = 1'b1;
  // strap has a pull-up, so released reads high
  assign boot_select_strap = strap_low ? 1'b0 : 1'b1;
  assign reset_req_n = reset_req_q;
  // fuse pins are not modelled here; the bench drives them
  task automatic press(input int n, input logic low);
    @(negedge core_clk);
    strap_low = low;
    reset_req_q = 1'b0; // held low n cycles
    repeat (n) @(negedge core_clk);
    reset_req_q = 1'b1;
  endtask
endmodule // bss_board

// *** tb/boot_source_select_tb.sv ***
// self-checking bench for the boot source select block
`timescale 1ns/1ps
module boot_source_select_tb;
  import bss_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ovr = 1'b0;
  logic prog = 1'b0;
  logic reset_req_n, strap, int_reset_n, boot_start;
  logic [1:0] boot_source;
  logic [1:0] exp_q[$];
  int seed = 20776;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int low_cnt = 0;
  localparam int TRIG_CYC = 4;
  localparam int HOLD_CYC = 20;
  initial forever #50 core_clk = ~core_clk;
  bss_board board (.core_clk(core_clk), .reset_req_n(reset_req_n), .boot_select_strap(strap));
  bss_top #(.TRIG_CYCLES(TRIG_CYC), .HOLD_CYCLES(HOLD_CYC)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .reset_req_n(reset_req_n), .boot_select_strap(strap), .fuse_boot_override(ovr),
    .fuses_programmed(prog), .int_reset_n(int_reset_n), .boot_start(boot_start),
    .boot_source(boot_source));
  task automatic check(input string name, input logic [1:0] exp, input logic [1:0] got);
    checks++;
    if (exp !== got) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_bit(input string name, input logic exp, input logic got);
    checks++;
    if (exp !== got) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // fuse wins only once programmed, then strap low
  function automatic logic [1:0] exp_src(input logic low, input logic o, input logic p);
    if (o && p) return BSS_SRC_FUSE;
    if (low) return BSS_SRC_USB_DL;
    return BSS_SRC_EMMC;
  endfunction
  task automatic report_and_stop;
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_boot;
    int k;
    k = 0;
    while (exp_q.size() > 0 && k < 300) begin
      @(negedge core_clk);
      k++;
    end
    // a boot that never came is a mismatch, not a silent skip
    if (exp_q.size() > 0) begin
      check_bit("boot_start", 1'b1, 1'b0);
      exp_q.delete();
    end
  endtask
  task automatic boot(input int n, input logic low, input logic o, input logic p);
    ovr = o;
    prog = p;
    exp_q.push_back(exp_src(low, o, p));
    board.press(n, low);
    wait_boot();
  endtask
  // monitor on the falling edge, where registered outputs have settled
  always @(negedge core_clk) begin
    cyc++;
    if (cyc > 6000) begin
      fail_count++;
      report_and_stop();
    end else begin
      if (int_reset_n === 1'b0) low_cnt++;
      if (boot_start === 1'b1) begin
        if (exp_q.size() == 0) check_bit("boot_start", 1'b0, 1'b1);
        else check("boot_source", exp_q.pop_front(), boot_source);
        check_bit("hold_min", 1'b1, low_cnt >= HOLD_CYC);
        check_bit("hold_max", 1'b1, low_cnt <= 2 * HOLD_CYC);
        low_cnt = 0;
      end
    end
  end
  initial begin
    int i;
    int r;
    exp_q.push_back(BSS_SRC_EMMC);
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    wait_boot();
    boot(TRIG_CYC, 1'b0, 1'b0, 1'b0);
    boot(TRIG_CYC, 1'b1, 1'b0, 1'b0);
    boot(TRIG_CYC + 1, 1'b1, 1'b1, 1'b0);
    boot(TRIG_CYC + 2, 1'b0, 1'b1, 1'b1);
    // one cycle short: no reset, and the latched source must not follow the inputs
    ovr = 1'b0;
    board.press(TRIG_CYC - 1, 1'b1);
    repeat (8) @(negedge core_clk);
    check_bit("int_reset_n", 1'b1, int_reset_n);
    repeat (32) @(negedge core_clk);
    check("boot_source", BSS_SRC_FUSE, boot_source);
    for (i = 0; i < 6; i++) begin
      r = $random(seed);
      boot(TRIG_CYC + int'(r[9:8]), r[0], r[1], r[2]);
    end
    // power-on reset again in mid-run, strap left as the last press set it
    exp_q.push_back(exp_src(board.strap_low, ovr, prog));
    rst_n = 1'b0;
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    wait_boot();
    report_and_stop();
  end
endmodule // boot_source_select_tb
